// [rtl/gd_cfg_pkg.sv]
// Purpose: constants for the gate driver configuration register block
// Assumes: mclk at 25 MHz, register port addressed by byte
// Notes: counts derive from the times below
//
// What this block does
// - Register sits at byte address ACh, resets to 00228000h.
// - Bits 27-26 pick output slew rate 25, 50, 125 or 200 V/us.
// - Bit 19 picks supply overvoltage trip level, 0 = 32 V, 1 = 20 V.
// - Bit 18 set enables supply overvoltage protection.
// - Bit 16 set lets overtemperature warning pull the fault pin low.
// - Bits 13-12 pick overcurrent deglitch 0.2, 0.6, 1.1 or 1.6 us.
// - Bit 11 picks overcurrent retry wait, 0 = 5 ms, 1 = 500 ms.
// - Mode 0: accepted overcurrent gives a fault latched until cleared.
// - Mode 1: overcurrent fault releases itself after the retry time.
// - Mode 2: overcurrent is reported only, outputs stay enabled.
// - Mode 3: overcurrent is neither reported nor acted on.
// - Bit 5 picks low-side demag threshold, 0 = 100 mA, 1 = 150 mA.
// - Bit 4 picks high-side demag threshold, 0 = 100 mA, 1 = 150 mA.
// - Bit 3 set enables active synchronous rectification.
// - Bit 2 set enables active asynchronous rectification.
// - Bits 1-0 pick sense gain 0.15, 0.3, 0.6 or 1.2 V/A.
package gd_cfg_pkg;
   localparam logic [7:0] CFG_ONE_ADDR = 8'hAC;
   localparam logic [31:0] CFG_ONE_RESET = 32'h00228000;
   localparam int PARITY_BIT = 31;
   localparam int SLEW_LSB = 26;
   localparam int OV_LEVEL_BIT = 19;
   localparam int OV_EN_BIT = 18;
   localparam int OVERTEMP_WARNING_REPORT_EN_BIT = 16;
   localparam int DEG_LSB = 12;
   localparam int RETRY_BIT = 11;
   localparam int OC_LVL_BIT = 10;
   localparam int MODE_LSB = 8;
   localparam int DEMAG_LS_BIT = 5;
   localparam int DEMAG_HS_BIT = 4;
   localparam int SYNC_RECT_BIT = 3;
   localparam int ASYNC_RECT_BIT = 2;
   localparam int GAIN_LSB = 0;
   typedef enum logic [1:0] {
      OC_LATCH,
      OC_RETRY,
      OC_REPORT,
      OC_IGNORE
   } oc_mode_t;
   localparam int MCLK_KHZ = 25000;
   localparam int DEG0_NS = 200;
   localparam int DEG1_NS = 600;
   localparam int DEG2_NS = 1100;
   localparam int DEG3_NS = 1600;
   localparam int DEG0_CYC = (DEG0_NS * MCLK_KHZ + 999999) / 1000000;
   localparam int DEG1_CYC = (DEG1_NS * MCLK_KHZ + 999999) / 1000000;
   localparam int DEG2_CYC = (DEG2_NS * MCLK_KHZ + 999999) / 1000000;
   localparam int DEG3_CYC = (DEG3_NS * MCLK_KHZ + 999999) / 1000000;
   localparam int DEG_W = 6;
   localparam int RETRY_SHORT_MS = 5;
   localparam int RETRY_LONG_MS = 500;
   localparam int RETRY_SHORT_CYC = RETRY_SHORT_MS * MCLK_KHZ;
   localparam int RETRY_LONG_CYC = RETRY_LONG_MS * MCLK_KHZ;
   localparam int RETRY_W = 24;
   localparam int SYNC_OC16 = 0;
   localparam int SYNC_OC24 = 1;
   localparam int SYNC_OV32 = 2;
   localparam int SYNC_OV20 = 3;
   localparam int SYNC_OTW = 4;
   localparam int SYNC_W = 5;
endpackage : gd_cfg_pkg

// [rtl/oc_guard_if.sv]
// Purpose: links the register block to its overcurrent guard
// Assumes: all signals on mclk
// Notes: ctrl side drives settings, guard side drives results
`timescale 1ns/1ps
`default_nettype none
interface oc_guard_if;
   logic oc_present;
   logic [1:0] deglitch_sel;
   logic retry_sel;
   gd_cfg_pkg::oc_mode_t mode;
   logic fault_clear;
   logic oc_fault;
   logic oc_shutdown;
   modport ctrl (
      output oc_present, deglitch_sel, retry_sel, mode, fault_clear,
      input oc_fault, oc_shutdown
   );
   modport guard (
      input oc_present, deglitch_sel, retry_sel, mode, fault_clear,
      output oc_fault, oc_shutdown
   );
endinterface : oc_guard_if
`default_nettype wire

// [rtl/pin_sync_filter.sv]
// Purpose: three-stage synchroniser with agreement filter
// Assumes: inputs asynchronous to mclk
// Notes: level changes once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module pin_sync_filter #(
   parameter int W = 1
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [W-1:0] pin_in,
   output logic [W-1:0] level
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] lvl;
   } sync_state_t;
   sync_state_t st;
   sync_state_t next_st;
   always_comb
   begin
      next_st = st;
      next_st.s1 = pin_in;
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
      // Take stage three where it agrees, else hold
      next_st.lvl = (st.s2 & st.s3) | (st.lvl & (st.s2 | st.s3));
   end
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         st <= '0;
      else
         st <= next_st;
   end
   assign level = st.lvl;
endmodule : pin_sync_filter
`default_nettype wire

// [rtl/oc_guard.sv]
// Purpose: overcurrent deglitch, fault modes and retry timer
// Assumes: oc_present already synchronised
// Notes: retry counts come from the top as parameters
`timescale 1ns/1ps
`default_nettype none
module oc_guard #(
   parameter logic [23:0] RETRY_SHORT = 24'h01E848,
   parameter logic [23:0] RETRY_LONG = 24'hBEBC20
) (
   input wire logic mclk,
   input wire logic rst,
   oc_guard_if.guard g
);
   typedef enum logic [2:0] {
      IDLE,
      QUAL,
      LATCHED,
      RETRY_WAIT,
      REPORTED
   } guard_fsm_t;
   typedef struct packed {
      guard_fsm_t fsm;
      logic [gd_cfg_pkg::DEG_W-1:0] deg_cnt;
      logic [gd_cfg_pkg::RETRY_W-1:0] retry_cnt;
      logic fault;
      logic shutdown;
   } guard_state_t;
   localparam logic [5:0] D0 = 6'(gd_cfg_pkg::DEG0_CYC);
   localparam logic [5:0] D1 = 6'(gd_cfg_pkg::DEG1_CYC);
   localparam logic [5:0] D2 = 6'(gd_cfg_pkg::DEG2_CYC);
   localparam logic [5:0] D3 = 6'(gd_cfg_pkg::DEG3_CYC);
   guard_state_t st;
   guard_state_t next_st;
   logic [5:0] deg_target;
   logic [23:0] retry_target;
   always_comb
   begin
      unique case (g.deglitch_sel)
         2'h0: deg_target = D0;
         2'h1: deg_target = D1;
         2'h2: deg_target = D2;
         2'h3: deg_target = D3;
      endcase
      retry_target = g.retry_sel ? RETRY_LONG : RETRY_SHORT;
      next_st = st;
      unique case (st.fsm)
         IDLE:
         begin
            if (g.oc_present && g.mode != gd_cfg_pkg::OC_IGNORE)
            begin
               next_st.fsm = QUAL;
               next_st.deg_cnt = 6'h01;
            end
         end
         QUAL:
         begin
            if (!g.oc_present || g.mode == gd_cfg_pkg::OC_IGNORE)
               next_st.fsm = IDLE;
            else if (st.deg_cnt < deg_target)
               next_st.deg_cnt = st.deg_cnt + 6'h01;
            else
            begin
               next_st.fault = 1'b1;
               next_st.retry_cnt = '0;
               unique case (g.mode)
                  gd_cfg_pkg::OC_LATCH:
                  begin
                     next_st.fsm = LATCHED;
                     next_st.shutdown = 1'b1;
                  end
                  gd_cfg_pkg::OC_RETRY:
                  begin
                     next_st.fsm = RETRY_WAIT;
                     next_st.shutdown = 1'b1;
                  end
                  gd_cfg_pkg::OC_REPORT:
                     next_st.fsm = REPORTED;
                  gd_cfg_pkg::OC_IGNORE:
                  begin
                     next_st.fsm = IDLE;
                     next_st.fault = 1'b0;
                  end
               endcase
            end
         end
         RETRY_WAIT:
         begin
            if (st.retry_cnt >= retry_target - 24'h000001)
            begin
               next_st.fsm = IDLE;
               next_st.fault = 1'b0;
               next_st.shutdown = 1'b0;
            end
            else
               next_st.retry_cnt = st.retry_cnt + 24'h000001;
         end
         LATCHED, REPORTED:
         begin
            // Clear restarts qualification if the event persists
            if (g.fault_clear)
            begin
               next_st.fsm = g.oc_present ? QUAL : IDLE;
               next_st.deg_cnt = 6'h01;
               next_st.fault = 1'b0;
               next_st.shutdown = 1'b0;
            end
         end
      endcase
   end
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         st <= '{fsm: IDLE, default: '0};
      else
         st <= next_st;
   end
   assign g.oc_fault = st.fault;
   assign g.oc_shutdown = st.shutdown;
endmodule : oc_guard
`default_nettype wire

// [rtl/gd_config_one.sv]
// Purpose: gate driver configuration register and its fault actions
// Assumes: register port and loader on mclk, comparators asynchronous
// Notes: unmapped reads return zero, unmapped writes are dropped
`timescale 1ns/1ps
`default_nettype none
module gd_config_one #(
   parameter logic [23:0] RETRY_SHORT_CYC =
      24'(gd_cfg_pkg::RETRY_SHORT_CYC),
   parameter logic [23:0] RETRY_LONG_CYC =
      24'(gd_cfg_pkg::RETRY_LONG_CYC)
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_wdata,
   output logic [31:0] reg_rdata,
   output logic reg_rvalid,
   input wire logic cfg_load,
   input wire logic [31:0] cfg_load_data,
   input wire logic fault_clear,
   input wire logic oc_16a_raw,
   input wire logic oc_24a_raw,
   input wire logic ov_32v_raw,
   input wire logic ov_20v_raw,
   input wire logic overtemp_warn_raw,
   output logic fault_out_n,
   output logic drivers_off,
   output logic [1:0] slew_rate_sel,
   output logic supply_overvoltage_level_sel,
   output logic supply_overvoltage_protect_en,
   output logic overtemp_warning_report_en,
   output logic [1:0] overcurrent_deglitch_sel,
   output logic overcurrent_retry_time_sel,
   output logic overcurrent_trip_level_sel,
   output logic [1:0] overcurrent_fault_mode,
   output logic demag_cmp_thresh_low_side,
   output logic demag_cmp_thresh_high_side,
   output logic sync_rectify_en,
   output logic async_rectify_en,
   output logic [1:0] current_sense_gain_sel,
   output logic parity_bit
);
   typedef struct packed {
      logic [31:0] cfg;
      logic [31:0] rdata;
      logic rvalid;
      logic ov_fault;
      logic fault_n;
      logic drv_off;
   } top_state_t;
   top_state_t st;
   top_state_t next_st;
   logic [gd_cfg_pkg::SYNC_W-1:0] raw_bus;
   logic [gd_cfg_pkg::SYNC_W-1:0] lvl;
   logic addr_hit;
   logic oc_sel;
   logic ov_sel;
   logic otw_report;
   oc_guard_if gif ();

   // Comparator inputs enter through the filtered synchroniser
   assign raw_bus = {overtemp_warn_raw, ov_20v_raw, ov_32v_raw,
                     oc_24a_raw, oc_16a_raw};
   pin_sync_filter #(
      .W(gd_cfg_pkg::SYNC_W)
   ) u_sync (
      .mclk(mclk),
      .rst(rst),
      .pin_in(raw_bus),
      .level(lvl)
   );

   // Guard settings straight from the stored fields
   assign gif.oc_present = oc_sel;
   assign gif.deglitch_sel =
      st.cfg[gd_cfg_pkg::DEG_LSB +: 2];
   assign gif.retry_sel = st.cfg[gd_cfg_pkg::RETRY_BIT];
   assign gif.mode =
      gd_cfg_pkg::oc_mode_t'(st.cfg[gd_cfg_pkg::MODE_LSB +: 2]);
   assign gif.fault_clear = fault_clear;
   oc_guard #(
      .RETRY_SHORT(RETRY_SHORT_CYC),
      .RETRY_LONG(RETRY_LONG_CYC)
   ) u_guard (
      .mclk(mclk),
      .rst(rst),
      .g(gif)
   );

   always_comb
   begin
      addr_hit = reg_addr == gd_cfg_pkg::CFG_ONE_ADDR;
      // Trip level picks which comparator counts
      oc_sel = st.cfg[gd_cfg_pkg::OC_LVL_BIT] ?
         lvl[gd_cfg_pkg::SYNC_OC24] :
         lvl[gd_cfg_pkg::SYNC_OC16];
      ov_sel = st.cfg[gd_cfg_pkg::OV_LEVEL_BIT] ?
         lvl[gd_cfg_pkg::SYNC_OV20] :
         lvl[gd_cfg_pkg::SYNC_OV32];
      otw_report = lvl[gd_cfg_pkg::SYNC_OTW] &
         st.cfg[gd_cfg_pkg::OVERTEMP_WARNING_REPORT_EN_BIT];
      next_st = st;
      // Loader wins over a register write in the same cycle
      if (cfg_load)
         next_st.cfg = cfg_load_data;
      else if (reg_wr && addr_hit)
         next_st.cfg = reg_wdata;
      next_st.rvalid = reg_rd;
      if (reg_rd)
         next_st.rdata = addr_hit ? st.cfg : 32'h00000000;
      next_st.ov_fault = ov_sel &
         st.cfg[gd_cfg_pkg::OV_EN_BIT];
      next_st.drv_off = gif.oc_shutdown | st.ov_fault;
      next_st.fault_n = ~(gif.oc_fault | st.ov_fault |
         otw_report);
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         st <= '{cfg: gd_cfg_pkg::CFG_ONE_RESET, fault_n: 1'b1,
                 default: '0};
      else
         st <= next_st;
   end

   assign reg_rdata = st.rdata;
   assign reg_rvalid = st.rvalid;
   assign fault_out_n = st.fault_n;
   assign drivers_off = st.drv_off;
   assign slew_rate_sel = st.cfg[gd_cfg_pkg::SLEW_LSB +: 2];
   assign supply_overvoltage_level_sel =
      st.cfg[gd_cfg_pkg::OV_LEVEL_BIT];
   assign supply_overvoltage_protect_en =
      st.cfg[gd_cfg_pkg::OV_EN_BIT];
   assign overtemp_warning_report_en =
      st.cfg[gd_cfg_pkg::OVERTEMP_WARNING_REPORT_EN_BIT];
   assign overcurrent_deglitch_sel = st.cfg[gd_cfg_pkg::DEG_LSB +: 2];
   assign overcurrent_retry_time_sel = st.cfg[gd_cfg_pkg::RETRY_BIT];
   assign overcurrent_trip_level_sel =
      st.cfg[gd_cfg_pkg::OC_LVL_BIT];
   assign overcurrent_fault_mode = st.cfg[gd_cfg_pkg::MODE_LSB +: 2];
   assign demag_cmp_thresh_low_side =
      st.cfg[gd_cfg_pkg::DEMAG_LS_BIT];
   assign demag_cmp_thresh_high_side =
      st.cfg[gd_cfg_pkg::DEMAG_HS_BIT];
   assign sync_rectify_en = st.cfg[gd_cfg_pkg::SYNC_RECT_BIT];
   assign async_rectify_en =
      st.cfg[gd_cfg_pkg::ASYNC_RECT_BIT];
   assign current_sense_gain_sel =
      st.cfg[gd_cfg_pkg::GAIN_LSB +: 2];
   assign parity_bit = st.cfg[gd_cfg_pkg::PARITY_BIT];
endmodule : gd_config_one
`default_nettype wire

// [test/gd_config_one_properties.sv]
// Purpose: port checks for the gate driver config register
// Assumes: bound to gd_config_one, one clock domain
// Notes: fields compared as one masked word
`timescale 1ns/1ps
`default_nettype none
module gd_config_one_properties #(
   parameter logic [23:0] RETRY_SHORT_CYC = 24'h000014,
   parameter logic [23:0] RETRY_LONG_CYC = 24'h000028
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_wdata,
   input wire logic [31:0] reg_rdata,
   input wire logic reg_rvalid,
   input wire logic cfg_load,
   input wire logic [31:0] cfg_load_data,
   input wire logic ov_32v_raw,
   input wire logic fault_out_n,
   input wire logic drivers_off,
   input wire logic [1:0] slew_rate_sel,
   input wire logic supply_overvoltage_level_sel,
   input wire logic supply_overvoltage_protect_en,
   input wire logic overtemp_warning_report_en,
   input wire logic [1:0] overcurrent_deglitch_sel,
   input wire logic overcurrent_retry_time_sel,
   input wire logic overcurrent_trip_level_sel,
   input wire logic [1:0] overcurrent_fault_mode,
   input wire logic demag_cmp_thresh_low_side,
   input wire logic demag_cmp_thresh_high_side,
   input wire logic sync_rectify_en,
   input wire logic async_rectify_en,
   input wire logic [1:0] current_sense_gain_sel,
   input wire logic parity_bit
);
   localparam logic [31:0] FMASK = 32'h8C0D3F3F;
   logic [31:0] fld;
   logic hit;
   assign hit = reg_addr == gd_cfg_pkg::CFG_ONE_ADDR;
   assign fld = {parity_bit, 3'h0, slew_rate_sel, 6'h0,
      supply_overvoltage_level_sel, supply_overvoltage_protect_en, 1'b0,
      overtemp_warning_report_en, 2'h0, overcurrent_deglitch_sel,
      overcurrent_retry_time_sel, overcurrent_trip_level_sel,
      overcurrent_fault_mode, 2'h0, demag_cmp_thresh_low_side,
      demag_cmp_thresh_high_side, sync_rectify_en, async_rectify_en,
      current_sense_gain_sel};
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);
   chk_write_fields: assert property (
      reg_wr && !cfg_load && hit |=> fld == ($past(reg_wdata) & FMASK))
      else $error("fields differ from written word");
   chk_load_fields: assert property (
      cfg_load |=> fld == ($past(cfg_load_data) & FMASK))
      else $error("fields differ from loaded word");
   chk_fields_hold: assert property (
      !reg_wr && !cfg_load |=> $stable(fld))
      else $error("fields changed without a write");
   chk_rvalid_follows: assert property (
      reg_rvalid == $past(reg_rd))
      else $error("read valid not one cycle after read");
   chk_unmapped_zero: assert property (
      reg_rd && !hit |=> reg_rdata == 32'h0)
      else $error("unmapped read not zero");
   chk_read_value: assert property (
      reg_rd && hit |=> (reg_rdata & FMASK) == $past(fld))
      else $error("read data differs from fields");
   chk_rdata_hold: assert property (
      !reg_rd |=> $stable(reg_rdata))
      else $error("read data changed without a read");
   chk_off_faults: assert property (
      drivers_off |-> !fault_out_n)
      else $error("outputs off without fault indication");
   chk_ov_trip: assert property (
      (supply_overvoltage_protect_en && !supply_overvoltage_level_sel
      && ov_32v_raw)[*8] |-> drivers_off && !fault_out_n)
      else $error("overvoltage not acted on");
   chk_mode_quiet: assert property (
      (overcurrent_fault_mode == 2'h3 && !supply_overvoltage_protect_en
      && !overtemp_warning_report_en)[*8] |-> fault_out_n && !drivers_off)
      else $error("ignored overcurrent gave a fault");
   cover property (reg_wr && hit);
   cover property (reg_rd && !hit);
   cover property ($rose(drivers_off));
   cover property ($fell(fault_out_n) && !drivers_off);
endmodule : gd_config_one_properties
bind gd_config_one gd_config_one_properties #(
   .RETRY_SHORT_CYC(RETRY_SHORT_CYC),
   .RETRY_LONG_CYC(RETRY_LONG_CYC)
) gd_config_one_properties_inst (.*);
`default_nettype wire

// [test/gd_config_one_bench.sv]
// Purpose: register and fault action tests for gd_config_one
// Assumes: retry counts shortened to 20 and 40 cycles
// Notes: settle waits cover the input synchroniser
`timescale 1ns/1ps
`default_nettype none
module gd_config_one_bench;
   localparam logic [7:0] ADDR = gd_cfg_pkg::CFG_ONE_ADDR;
   localparam logic [31:0] HI = 32'h0C0D3F00;
   localparam logic [31:0] LO = 32'h8000003F;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic reg_wr = 1'b0, reg_rd = 1'b0, cfg_load = 1'b0, fault_clear = 1'b0;
   logic oc_16a_raw = 1'b0, oc_24a_raw = 1'b0, ov_32v_raw = 1'b0;
   logic ov_20v_raw = 1'b0, overtemp_warn_raw = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0, cfg_load_data = 32'h0;
   logic [31:0] reg_rdata, fld, got;
   logic reg_rvalid, fault_out_n, drivers_off, parity_bit;
   logic supply_overvoltage_level_sel, supply_overvoltage_protect_en;
   logic overtemp_warning_report_en, overcurrent_retry_time_sel;
   logic overcurrent_trip_level_sel, demag_cmp_thresh_low_side;
   logic demag_cmp_thresh_high_side, sync_rectify_en, async_rectify_en;
   logic [1:0] slew_rate_sel, overcurrent_deglitch_sel;
   logic [1:0] overcurrent_fault_mode, current_sense_gain_sel;
   int bad_count = 0, compares = 0, cycles = 0;
   logic [31:0] vals [6] = '{32'hFFFFFFFF, 32'h8C0D3F3F, 32'h73F2C0C0,
      32'h04011101, 32'h08082202, 32'h00228000};
   assign fld = {parity_bit, 3'h0, slew_rate_sel, 6'h0,
      supply_overvoltage_level_sel, supply_overvoltage_protect_en, 1'b0,
      overtemp_warning_report_en, 2'h0, overcurrent_deglitch_sel,
      overcurrent_retry_time_sel, overcurrent_trip_level_sel,
      overcurrent_fault_mode, 2'h0, demag_cmp_thresh_low_side,
      demag_cmp_thresh_high_side, sync_rectify_en, async_rectify_en,
      current_sense_gain_sel};
   gd_config_one #(
      .RETRY_SHORT_CYC(24'h000014),
      .RETRY_LONG_CYC(24'h000028)
   ) gd_config_one_inst (.*);
   always #20 mclk = ~mclk;
   task automatic finish_test;
      $display("compares %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : finish_test
   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         bad_count++;
         finish_test();
      end
   end
   task automatic check(input string name, input logic [31:0] seen, exp);
      compares++;
      if (seen !== exp)
      begin
         $display("unexpected %s expected %h seen %h", name, exp, seen);
         bad_count++;
      end
   endtask : check
   task automatic flags(input logic d, input logic f);
      check("drivers_off", {31'h0, drivers_off}, {31'h0, d});
      check("fault_out_n", {31'h0, fault_out_n}, {31'h0, f});
   endtask : flags
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : cyc
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
      #1;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1;
      got = reg_rdata;
      check("read valid", {31'h0, reg_rvalid}, 32'h1);
   endtask : rd
   task automatic clr;
      @(posedge mclk);
      fault_clear <= 1'b1;
      @(posedge mclk);
      fault_clear <= 1'b0;
      cyc(4);
   endtask : clr
   initial
   begin
      repeat (4) @(posedge mclk);
      rst <= 1'b0;
      #1;
      check("reset fields", fld, 32'h0);
      flags(1'b0, 1'b1);
      rd(ADDR);
      check("reset word", got, 32'h00228000);
      $display("test reset done");
      foreach (vals[i])
      begin
         wr(ADDR, vals[i]);
         check("fld hi", fld & HI, vals[i] & HI);
         check("fld lo", fld & LO, vals[i] & LO);
         rd(ADDR);
         check("read back", got, vals[i]);
      end
      wr(8'hAE, 32'hFFFFFFFF);
      rd(ADDR);
      check("after unmapped write", got, vals[5]);
      rd(8'hAE);
      check("unmapped read", got, 32'h0);
      @(posedge mclk);
      cfg_load <= 1'b1;
      cfg_load_data <= 32'h00228001;
      reg_addr <= ADDR;
      reg_wdata <= 32'hFFFFFFFF;
      reg_wr <= 1'b1;
      @(posedge mclk);
      cfg_load <= 1'b0;
      reg_wr <= 1'b0;
      #1;
      check("loaded fields", fld, 32'h1);
      rst <= 1'b1;
      cyc(2);
      check("reset again", fld, 32'h0);
      rst <= 1'b0;
      cyc(1);
      rd(ADDR);
      check("reset word again", got, 32'h00228000);
      $display("test registers done");
      for (int s = 0; s < 2; s++)
      begin
         wr(ADDR, 32'h00040000 | (32'(s) << 19));
         {ov_20v_raw, ov_32v_raw} <= (s == 1) ? 2'b10 : 2'b01;
         cyc(12);
         flags(1'b1, 1'b0);
         {ov_20v_raw, ov_32v_raw} <= (s == 1) ? 2'b01 : 2'b10;
         cyc(12);
         flags(1'b0, 1'b1);
         wr(ADDR, 32'h0);
         {ov_20v_raw, ov_32v_raw} <= 2'b11;
         cyc(12);
         flags(1'b0, 1'b1);
         {ov_20v_raw, ov_32v_raw} <= 2'b00;
         cyc(12);
      end
      wr(ADDR, 32'h00010000);
      overtemp_warn_raw <= 1'b1;
      cyc(12);
      flags(1'b0, 1'b0);
      wr(ADDR, 32'h0);
      cyc(2);
      flags(1'b0, 1'b1);
      overtemp_warn_raw <= 1'b0;
      $display("test supply and warning done");
      oc_16a_raw <= 1'b1;
      cyc(20);
      flags(1'b1, 1'b0);
      oc_16a_raw <= 1'b0;
      cyc(10);
      flags(1'b1, 1'b0);
      clr();
      flags(1'b0, 1'b1);
      wr(ADDR, 32'h400);
      oc_16a_raw <= 1'b1;
      cyc(20);
      flags(1'b0, 1'b1);
      oc_24a_raw <= 1'b1;
      cyc(20);
      flags(1'b1, 1'b0);
      {oc_16a_raw, oc_24a_raw} <= 2'b00;
      clr();
      wr(ADDR, 32'h3000);
      oc_16a_raw <= 1'b1;
      cyc(30);
      flags(1'b0, 1'b1);
      cyc(25);
      flags(1'b1, 1'b0);
      oc_16a_raw <= 1'b0;
      clr();
      for (int r = 0; r < 2; r++)
      begin
         wr(ADDR, 32'h100 | (32'(r) << 11));
         oc_16a_raw <= 1'b1;
         for (int n = 0; n < 80 && drivers_off !== 1'b1; n++)
            cyc(1);
         oc_16a_raw <= 1'b0;
         cyc((r == 1) ? 34 : 14);
         flags(1'b1, 1'b0);
         cyc(12);
         flags(1'b0, 1'b1);
      end
      wr(ADDR, 32'h200);
      oc_16a_raw <= 1'b1;
      cyc(20);
      flags(1'b0, 1'b0);
      oc_16a_raw <= 1'b0;
      cyc(10);
      flags(1'b0, 1'b0);
      clr();
      flags(1'b0, 1'b1);
      wr(ADDR, 32'h300);
      oc_16a_raw <= 1'b1;
      cyc(60);
      flags(1'b0, 1'b1);
      oc_16a_raw <= 1'b0;
      $display("test overcurrent done");
      finish_test();
   end
endmodule : gd_config_one_bench
`default_nettype wire
